//--- hw/converter_monitor_pkg.sv
package converter_monitor_pkg;

  // Register pointers as sent in the register byte
  localparam logic [7:0] REG_FAULT_STATUS    = 8'h79;
  localparam logic [7:0] REG_INPUT_VOLTAGE   = 8'h88;
  localparam logic [7:0] REG_OUTPUT_VOLTAGE  = 8'h8b;
  localparam logic [7:0] REG_OUTPUT_CURRENT  = 8'h8c;
  localparam logic [7:0] REG_THERMAL         = 8'h8d;

  // Write-form address bytes; bit 0 is the read/write flag
  localparam logic [7:0] ADDR_BYTE_FLOAT     = 8'h02;
  localparam logic [7:0] ADDR_BYTE_STRAPPED  = 8'h06;

  // Fault status word layout
  localparam int         BIT_INPUT_LOW       = 0;
  localparam int         BIT_INPUT_HIGH      = 1;
  localparam int         BIT_OUTPUT_WINDOW   = 2;
  localparam int         BIT_OVERCURRENT     = 3;
  localparam int         BIT_HEAT            = 4;
  localparam int         LIVE_COUNT          = 5;
  localparam int         LOG_BASE            = 8;

  localparam logic [15:0] STATUS_RESET       = 16'h0000;
  localparam logic [15:0] READING_RESET      = 16'h0000;
  localparam logic [15:0] UNMAPPED_VALUE     = 16'h0000;

  localparam logic [3:0]  BITS_PER_BYTE      = 4'h8;
  localparam logic [3:0]  FIRST_BIT_SENT     = 4'h1;

  // Comparator results from the analog protection side
  typedef struct packed {
    logic input_low_trip;
    logic input_low_release;
    logic input_high_trip;
    logic input_high_release;
    logic output_window;
    logic overcurrent;
    logic heat;
  } fault_sense_type;

  // Readings from the measurement logic; thermal is two's complement
  typedef struct packed {
    logic [15:0] input_voltage_reading;
    logic [15:0] output_voltage_reading;
    logic [15:0] output_current_reading;
    logic [15:0] thermal_reading;
  } readings_type;

  typedef enum logic [9:0] {
    ST_IDLE    = 10'b0000000001,
    ST_ADDR    = 10'b0000000010,
    ST_ACK_W   = 10'b0000000100,
    ST_REG     = 10'b0000001000,
    ST_REG_ACK = 10'b0000010000,
    ST_ACK_R   = 10'b0000100000,
    ST_TX      = 10'b0001000000,
    ST_MACK    = 10'b0010000000,
    ST_MACK_GO = 10'b0100000000,
    ST_IGNORE  = 10'b1000000000
  } link_state_type;

endpackage

//--- hw/converter_monitor_regs.sv
`timescale 1ns/1ps

// How it works
// - Bank of five registers at 0x79, 0x88, 0x8B, 0x8C, 0x8D read over serial port.
// - All registers read-only; master writes never change any register.
// - Status word 16 bits; low byte holds live fault flags meaning output off.
// - High byte holds sticky logged faults, kept after the live condition goes away.
// - Logged faults clear only on power-down or remote off; no access clears them.
// - Bit 0 sets below undervoltage off threshold, clears above higher on threshold.
// - Bit 1 sets above overvoltage off threshold, clears below lower on threshold.
// - Bit 2 flags output voltage outside shutdown window, otherwise zero.
// - Bit 3 set when output current above shutdown limit, else zero.
// - Bit 4 set when temperature above shutdown trip point, else zero.
// - Bits 8 to 12 log bits 0 to 4 in the same order.
// - Input voltage reading is 16-bit unsigned, one millivolt per count.
// - Low byte carries the eight low bits, high byte the eight high bits.
// - Slave only; write address, register byte, restart read, low then high byte.
// - Answer at address 0x2 with strap floating, 0x6 with strap grounded.
// - Temperature reading is two's complement, 65535 meaning minus one degree.
module converter_monitor_regs (
  input  wire logic                                clk,
  input  wire logic                                sys_rst,
  input  wire logic                                scl_in,
  input  wire logic                                sda_in,
  output logic                                     sda_out,
  output logic                                     sda_oe,
  input  wire logic                                addr_strap_in,
  input  wire logic                                remote_off_in,
  input  wire converter_monitor_pkg::fault_sense_type fault_sense,
  input  wire converter_monitor_pkg::readings_type readings,
  output logic [15:0]                              fault_status_word
);

  // Sync word layout: the four pins on top, the sense bits below
  localparam int                SENSE_W    = $bits(converter_monitor_pkg::fault_sense_type);
  localparam int                SYNC_W     = SENSE_W + 4;
  localparam int                POS_SCL    = SYNC_W - 1;
  localparam int                POS_SDA    = SYNC_W - 2;
  localparam int                POS_STRAP  = SYNC_W - 3;
  localparam int                POS_REMOTE = SYNC_W - 4;
  // Rest state: bus idle, strap floating, remote off, no fault sensed.
  // Sense resting high would log phantom faults that outlive the reset.
  localparam logic [SYNC_W-1:0] SYNC_IDLE  = {4'hf, {SENSE_W{1'b0}}};

  logic [SYNC_W-1:0]                    sync1;
  logic [SYNC_W-1:0]                    sync2;
  logic                                 scl_prev;
  logic                                 sda_prev;
  logic                                 scl_s;
  logic                                 sda_s;
  logic                                 strap_s;
  logic                                 remote_off_s;
  converter_monitor_pkg::fault_sense_type sense_s;
  logic                                 scl_rise;
  logic                                 scl_fall;
  logic                                 start_seen;
  logic                                 stop_seen;
  logic [7:0]                           own_addr;

  converter_monitor_pkg::link_state_type state;
  converter_monitor_pkg::link_state_type next_state;
  logic [3:0]                           bit_cnt;
  logic [3:0]                           next_bit_cnt;
  logic [7:0]                           rx_byte;
  logic [7:0]                           next_rx_byte;
  logic [7:0]                           tx_byte;
  logic [7:0]                           next_tx_byte;
  logic [7:0]                           reg_ptr;
  logic [7:0]                           next_reg_ptr;
  logic [15:0]                          snapshot;
  logic [15:0]                          next_snapshot;
  logic                                 high_sent;
  logic                                 next_high_sent;
  logic                                 next_sda_oe;
  logic [15:0]                          next_fault_status_word;

  // Read-only decode; anything unmapped returns zero
  function automatic logic [15:0] reg_value(
    input logic [7:0]                          ptr,
    input logic [15:0]                         status,
    input converter_monitor_pkg::readings_type rd
  );
    logic [15:0] v;
    v = converter_monitor_pkg::UNMAPPED_VALUE;
    unique case (ptr)
      converter_monitor_pkg::REG_FAULT_STATUS:   v = status;
      converter_monitor_pkg::REG_INPUT_VOLTAGE:  v = rd.input_voltage_reading;
      converter_monitor_pkg::REG_OUTPUT_VOLTAGE: v = rd.output_voltage_reading;
      converter_monitor_pkg::REG_OUTPUT_CURRENT: v = rd.output_current_reading;
      converter_monitor_pkg::REG_THERMAL:        v = rd.thermal_reading;
      default:                                   v = converter_monitor_pkg::UNMAPPED_VALUE;
    endcase
    return v;
  endfunction

  // Every pin passes two flip-flops; only the second stage is ever read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1    <= SYNC_IDLE;
      sync2    <= SYNC_IDLE;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      sync1    <= {scl_in, sda_in, addr_strap_in, remote_off_in, fault_sense};
      sync2    <= sync1;
      scl_prev <= scl_s;
      sda_prev <= sda_s;
    end
  end

  assign scl_s        = sync2[POS_SCL];
  assign sda_s        = sync2[POS_SDA];
  assign strap_s      = sync2[POS_STRAP];
  assign remote_off_s = sync2[POS_REMOTE];
  assign sense_s      = sync2[SENSE_W-1:0];

  assign scl_rise   = scl_s & ~scl_prev;
  assign scl_fall   = ~scl_s & scl_prev;
  assign start_seen = scl_s & scl_prev & sda_prev & ~sda_s;
  assign stop_seen  = scl_s & scl_prev & ~sda_prev & sda_s;

  // Strap is read live, so it must be settled before the first transfer
  assign own_addr = strap_s ? converter_monitor_pkg::ADDR_BYTE_FLOAT
                            : converter_monitor_pkg::ADDR_BYTE_STRAPPED;

  // Status word: live flags and their sticky log
  always_comb begin
    logic [converter_monitor_pkg::LIVE_COUNT-1:0] live;
    logic [converter_monitor_pkg::LIVE_COUNT-1:0] logged;
    live   = fault_status_word[converter_monitor_pkg::LIVE_COUNT-1:0];
    logged = fault_status_word[converter_monitor_pkg::LOG_BASE +:
                               converter_monitor_pkg::LIVE_COUNT];
    // Hysteresis: trip wins, release clears, otherwise hold
    if (sense_s.input_low_trip) begin
      live[converter_monitor_pkg::BIT_INPUT_LOW] = 1'b1;
    end else if (sense_s.input_low_release) begin
      live[converter_monitor_pkg::BIT_INPUT_LOW] = 1'b0;
    end
    if (sense_s.input_high_trip) begin
      live[converter_monitor_pkg::BIT_INPUT_HIGH] = 1'b1;
    end else if (sense_s.input_high_release) begin
      live[converter_monitor_pkg::BIT_INPUT_HIGH] = 1'b0;
    end
    live[converter_monitor_pkg::BIT_OUTPUT_WINDOW] = sense_s.output_window;
    live[converter_monitor_pkg::BIT_OVERCURRENT]   = sense_s.overcurrent;
    live[converter_monitor_pkg::BIT_HEAT]          = sense_s.heat;
    // A fault arriving during remote off still logs: set beats clear
    if (remote_off_s) begin
      logged = '0;
    end
    logged = logged | live;
    next_fault_status_word = converter_monitor_pkg::STATUS_RESET;
    next_fault_status_word[converter_monitor_pkg::LIVE_COUNT-1:0] = live;
    next_fault_status_word[converter_monitor_pkg::LOG_BASE +:
                           converter_monitor_pkg::LIVE_COUNT] = logged;
  end

  // Serial slave; the bus never reaches the status logic, so no write lands
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_rx_byte   = rx_byte;
    next_tx_byte   = tx_byte;
    next_reg_ptr   = reg_ptr;
    next_snapshot  = snapshot;
    next_high_sent = high_sent;
    next_sda_oe    = sda_oe;
    if (start_seen) begin
      next_state   = converter_monitor_pkg::ST_ADDR;
      next_bit_cnt = '0;
      next_sda_oe  = 1'b0;
    end else if (stop_seen) begin
      // A stop mid-byte drops the transfer; the pointer is kept
      next_state  = converter_monitor_pkg::ST_IDLE;
      next_sda_oe = 1'b0;
    end else begin
      unique case (state)
        converter_monitor_pkg::ST_IDLE,
        converter_monitor_pkg::ST_IGNORE: begin
          // Released until the next start or stop
          next_sda_oe = 1'b0;
        end
        // Bits are taken as the clock rises; the answer waits for the fall,
        // so the data line never moves while the clock is high
        converter_monitor_pkg::ST_ADDR,
        converter_monitor_pkg::ST_REG: begin
          if (scl_rise && bit_cnt != converter_monitor_pkg::BITS_PER_BYTE) begin
            next_rx_byte = {rx_byte[6:0], sda_s};
            next_bit_cnt = bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == converter_monitor_pkg::BITS_PER_BYTE) begin
            if (state == converter_monitor_pkg::ST_REG) begin
              next_reg_ptr = rx_byte;
              next_sda_oe  = 1'b1;
              next_state   = converter_monitor_pkg::ST_REG_ACK;
            end else if (rx_byte[7:1] == own_addr[7:1]) begin
              next_sda_oe = 1'b1;
              if (rx_byte[0]) begin
                // Whole word captured at once so both bytes match
                next_snapshot  = reg_value(reg_ptr, fault_status_word, readings);
                next_high_sent = 1'b0;
                next_state     = converter_monitor_pkg::ST_ACK_R;
              end else begin
                next_state = converter_monitor_pkg::ST_ACK_W;
              end
            end else begin
              next_state = converter_monitor_pkg::ST_IGNORE;
            end
          end
        end
        converter_monitor_pkg::ST_ACK_W: begin
          // Pointer byte follows the write acknowledge
          if (scl_fall) begin
            next_sda_oe  = 1'b0;
            next_bit_cnt = '0;
            next_state   = converter_monitor_pkg::ST_REG;
          end
        end
        converter_monitor_pkg::ST_REG_ACK: begin
          // Further bytes are data writes: left unacknowledged and dropped
          if (scl_fall) begin
            next_sda_oe = 1'b0;
            next_state  = converter_monitor_pkg::ST_IGNORE;
          end
        end
        converter_monitor_pkg::ST_ACK_R: begin
          // First data bit drives as the acknowledge clock falls
          if (scl_fall) begin
            next_tx_byte = snapshot[7:0];
            next_sda_oe  = ~snapshot[7];
            next_bit_cnt = converter_monitor_pkg::FIRST_BIT_SENT;
            next_state   = converter_monitor_pkg::ST_TX;
          end
        end
        converter_monitor_pkg::ST_TX: begin
          // A new bit goes out only after a falling clock edge
          if (scl_fall) begin
            if (bit_cnt == converter_monitor_pkg::BITS_PER_BYTE) begin
              next_sda_oe = 1'b0;
              next_state  = converter_monitor_pkg::ST_MACK;
            end else begin
              next_sda_oe  = ~tx_byte[6];
              next_tx_byte = {tx_byte[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 4'h1;
            end
          end
        end
        converter_monitor_pkg::ST_MACK: begin
          // Master acknowledge after the low byte asks for the high byte
          // A refusal, or any answer after the high byte, ends the read
          if (scl_rise) begin
            if (!sda_s && !high_sent) begin
              next_high_sent = 1'b1;
              next_state     = converter_monitor_pkg::ST_MACK_GO;
            end else begin
              next_state = converter_monitor_pkg::ST_IGNORE;
            end
          end
        end
        converter_monitor_pkg::ST_MACK_GO: begin
          if (scl_fall) begin
            next_tx_byte = snapshot[15:8];
            next_sda_oe  = ~snapshot[15];
            next_bit_cnt = converter_monitor_pkg::FIRST_BIT_SENT;
            next_state   = converter_monitor_pkg::ST_TX;
          end
        end
        default: begin
          next_state  = converter_monitor_pkg::ST_IDLE;
          next_sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Registers only; every next value but the constant-low sda_out is formed above
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state             <= converter_monitor_pkg::ST_IDLE;
      bit_cnt           <= '0;
      rx_byte           <= '0;
      tx_byte           <= '0;
      reg_ptr           <= '0;
      snapshot          <= converter_monitor_pkg::READING_RESET;
      high_sent         <= 1'b0;
      sda_oe            <= 1'b0;
      sda_out           <= 1'b0;
      fault_status_word <= converter_monitor_pkg::STATUS_RESET;
    end else begin
      state             <= next_state;
      bit_cnt           <= next_bit_cnt;
      rx_byte           <= next_rx_byte;
      tx_byte           <= next_tx_byte;
      reg_ptr           <= next_reg_ptr;
      snapshot          <= next_snapshot;
      high_sent         <= next_high_sent;
      sda_oe            <= next_sda_oe;
      sda_out           <= 1'b0;
      fault_status_word <= next_fault_status_word;
    end
  end

endmodule

//--- verif/converter_monitor_regs_sva.sv
`timescale 1ns/1ps
module converter_monitor_regs_sva (
  input wire logic                                   clk,
  input wire logic                                   sys_rst,
  input wire logic                                   scl_in,
  input wire logic                                   sda_in,
  input wire logic                                   sda_out,
  input wire logic                                   sda_oe,
  input wire logic                                   addr_strap_in,
  input wire logic                                   remote_off_in,
  input wire converter_monitor_pkg::fault_sense_type fault_sense,
  input wire converter_monitor_pkg::readings_type    readings,
  input wire logic [15:0]                            fault_status_word
);
  wire [15:0] w = fault_status_word;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Pins reach the status word three edges late; follow checks need a clean history
  logic [2:0] since_rst;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      since_rst <= 3'h0;
    end else if (since_rst != 3'h4) begin
      since_rst <= since_rst + 3'h1;
    end
  end
  AST_RSV: assert property (w[15:13] == 3'h0 && w[7:5] == 3'h0)
    else $error("reserved status bits set");
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data line driven high");
  AST_LOG_SET: assert property (!$past(remote_off_in, 2) && w[4:0] != 5'h00 |=>
    (w[12:8] & $past(w[4:0])) == $past(w[4:0])) else $error("live fault not logged");
  AST_LOG_HOLD: assert property (($past(w[12:8]) & ~w[12:8]) != 5'h00 |->
    $past(remote_off_in, 2) || $past(remote_off_in, 3) || $past(remote_off_in, 4))
    else $error("logged fault lost without remote off");
  AST_FOLLOW: assert property (since_rst == 3'h4 |-> w[4:2] ==
    {$past(fault_sense.heat, 3), $past(fault_sense.overcurrent, 3),
     $past(fault_sense.output_window, 3)}) else $error("live fault bits wrong");
  AST_LOW_HYST: assert property (since_rst == 3'h4 |-> w[0] ==
    ($past(fault_sense.input_low_trip, 3) ||
     (!$past(fault_sense.input_low_release, 3) && $past(w[0])))) else $error("bit0 wrong");
  AST_HIGH_HYST: assert property (since_rst == 3'h4 |-> w[1] ==
    ($past(fault_sense.input_high_trip, 3) ||
     (!$past(fault_sense.input_high_release, 3) && $past(w[1])))) else $error("bit1 wrong");
  AST_OE_SCL_LOW: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data changed while clock high");
  cover property (w[12:8] == 5'h1f);
  cover property ($rose(sda_oe));
  cover property ($fell(w[8]));
endmodule

//--- verif/i2c_master_model.sv
`timescale 1ns/1ps
// Link master: SCL stands high and SDA is released between frames
module i2c_master_model #(parameter int HP = 8) (
  input  wire logic clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_low
);
  initial scl = 1'b1;
  initial sda_low = 1'b0;
  task automatic ph(input logic c, input logic d);
    scl = c;
    sda_low = ~d;
    repeat (HP) @(negedge clk);
  endtask
  // SDA moves a phase after SCL falls, so no data edge looks like start or stop
  task automatic xfer(input logic b, output logic r);
    ph(1'b0, ~sda_low);
    ph(1'b0, b);
    ph(1'b1, b);
    r = sda;
  endtask
  // 1 gives a start or repeated start, 0 a stop
  task automatic cond(input logic x);
    logic r;
    xfer(x, r);
    ph(1'b1, ~x);
  endtask
  task automatic bytex(input logic [7:0] d, output logic [7:0] q);
    for (int i = 7; i >= 0; i--)
      xfer(d[i], q[i]);
  endtask
  // Write form repeats the pointer as a data byte; reads ack low byte, not high
  task automatic frame(input logic [7:0] ab, input logic [7:0] ptr, input logic wr,
                       output logic [15:0] v, output logic [2:0] nak);
    logic [7:0] q;
    cond(1'b1);
    bytex(ab, q);
    xfer(1'b1, nak[2]);
    bytex(ptr, q);
    xfer(1'b1, nak[1]);
    if (wr) begin
      bytex(ptr, q);
      xfer(1'b1, nak[0]);
    end else begin
      cond(1'b1);
      bytex(ab | 8'h01, q);
      xfer(1'b1, nak[0]);
      bytex(8'hff, v[7:0]);
      xfer(1'b0, q[0]);
      bytex(8'hff, v[15:8]);
      xfer(1'b1, q[0]);
    end
    cond(1'b0);
  endtask
endmodule

//--- verif/tb_converter_monitor_regs.sv
`timescale 1ns/1ps
module tb_converter_monitor_regs;
  logic        clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        scl;
  logic        m_low;
  logic        sda_oe;
  logic        strap = 1'b1;
  logic        remote_off = 1'b1;
  logic [6:0]  fs = 7'h28;
  logic [15:0] fsw;
  logic [15:0] v;
  logic [63:0] rd = 64'h6d60_6a4c_29cc_ffc9;
  logic [2:0]  nak;
  int          errors = 0;
  int          n_checks = 0;
  wire         sda = ~(sda_oe | m_low);
  // Sense inputs beside the status word they give
  logic [22:0] seq [11] = '{23'h480101, 23'h080101, 23'h280100, 23'h300302, 23'h280300,
    23'h2c0704, 23'h280700, 23'h2a0f08, 23'h280f00, 23'h291f10, 23'h281f00};
  // Strap, pointer, word; status read twice as reading must not clear the log
  logic [24:0] rows [7] = '{25'h1886d60, 25'h08b6a4c, 25'h18c29cc, 25'h08dffc9,
    25'h1791f00, 25'h0791f00, 25'h1800000};
  converter_monitor_regs uut (.clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(), .sda_oe(sda_oe), .addr_strap_in(strap), .remote_off_in(remote_off),
    .fault_sense(fs), .readings(rd), .fault_status_word(fsw));
  i2c_master_model #(.HP(8)) mst (.clk(clk), .sda(sda), .scl(scl), .sda_low(m_low));
  always #4 clk = ~clk;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle(input logic [15:0] exp);
    repeat (6) @(negedge clk);
    chk(fsw, exp);
  endtask
  task automatic stop_test();
    $display("errors=%0d n_checks=%0d", errors, n_checks);
    if (errors == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    sys_rst = 1'b0;
    repeat (20) @(negedge clk);
    remote_off = 1'b0;
    foreach (seq[i]) begin
      fs = seq[i][22:16];
      settle(seq[i][15:0]);
    end
    foreach (rows[i]) begin
      strap = rows[i][24];
      mst.frame(strap ? 8'h02 : 8'h06, rows[i][23:16], 1'b0, v, nak);
      chk({13'h0000, nak}, 16'h0000);
      chk(v, rows[i][15:0]);
    end
    remote_off = 1'b1;
    settle(16'h0000);
    remote_off = 1'b0;
    settle(16'h0000);
    strap = 1'b1;
    mst.frame(8'h02, 8'h88, 1'b1, v, nak);
    chk({13'h0000, nak}, 16'h0001);
    mst.frame(8'h02, 8'h88, 1'b0, v, nak);
    chk(v, 16'h6d60);
    strap = 1'b0;
    mst.frame(8'h02, 8'h8d, 1'b0, v, nak);
    chk({13'h0000, nak}, 16'h0007);
    chk(v, 16'hffff);
    rd[15:0] = 16'h009b;
    mst.frame(8'h06, 8'h8d, 1'b0, v, nak);
    chk({13'h0000, nak}, 16'h0000);
    chk(v, 16'h009b);
    // A fault during remote off still logs: set beats the clear
    fs = 7'h29;
    remote_off = 1'b1;
    settle(16'h1010);
    sys_rst = 1'b1;
    repeat (2) @(negedge clk);
    chk(fsw, 16'h0000);
    // Release with the converter on: nothing may be logged out of reset
    fs = 7'h28;
    remote_off = 1'b0;
    sys_rst = 1'b0;
    settle(16'h0000);
    stop_test();
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    stop_test();
  end
endmodule
bind converter_monitor_regs converter_monitor_regs_sva sva_i (.clk(clk), .sys_rst(sys_rst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
  .addr_strap_in(addr_strap_in), .remote_off_in(remote_off_in), .fault_sense(fault_sense),
  .readings(readings), .fault_status_word(fault_status_word));
